/* include/cec_pkg.sv */
package cec_pkg;

  // ----------------------------------------------------------------
  // Widths and time base
  // ----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int MSDIV_W = 18;
  localparam int SEC_MS = 1000;
  localparam int SEND_DELAY_S = 1;
  localparam logic [10:0] SEND_DELAY_MS = 11'(SEND_DELAY_S * SEC_MS);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_SAMPLE = 8'h04;
  localparam logic [AW-1:0] OFS_GUARD = 8'h08;
  localparam logic [AW-1:0] OFS_TXPER = 8'h0C;
  localparam logic [AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [AW-1:0] OFS_CH_BASE = 8'h20;
  localparam logic [AW-1:0] OFS_CH_STRIDE = 8'h20;
  localparam logic [AW-1:0] OFS_CH_CFG = 8'h00;
  localparam logic [AW-1:0] OFS_CH_DEB = 8'h04;
  localparam logic [AW-1:0] OFS_CH_COS = 8'h08;
  localparam logic [AW-1:0] OFS_CH_DUR = 8'h0C;
  localparam logic [AW-1:0] OFS_CH_EVT = 8'h10;
  localparam logic [AW-1:0] OFS_CH_TIME = 8'h14;
  localparam logic [AW-1:0] OFS_CH_EVTSV = 8'h18;
  localparam logic [AW-1:0] OFS_CH_TIMESV = 8'h1C;

  // Field positions
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_CLR_BIT = 2;
  localparam int CFG_DET_LSB = 0;
  localparam int CFG_TEN_BIT = 2;
  localparam int ST_LVL_LSB = 0;
  localparam int ST_PEND_LSB = 2;
  localparam int ST_PER_BIT = 4;
  localparam int ST_VALID_BIT = 5;
  localparam int ST_LINK_BIT = 6;
  localparam int ST_FSM_LSB = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DET_LOW = 2'h0,
    DET_HIGH = 2'h1,
    DET_BOTH = 2'h2
  } cec_det_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DELAY = 4'h2,
    ST_GUARD = 4'h4,
    ST_SEND = 4'h8
  } cec_fsm_e;

  // Reset values
  localparam logic [1:0] RST_ENABLE = 2'h3;
  localparam logic [31:0] RST_SAMPLE = 32'h0001_5180;
  localparam logic [31:0] RST_GUARD = 32'h0000_0000;
  localparam logic [31:0] RST_TXPER = 32'h0000_0000;
  localparam cec_det_e RST_DET = DET_BOTH;
  localparam logic [31:0] RST_DEBOUNCE = 32'h0000_0064;
  localparam logic [31:0] RST_COS = 32'h0000_0001;
  localparam logic [31:0] RST_DUR = 32'h0000_0000;
  localparam logic [31:0] GUARD_SAT = 32'hFFFF_FFFF;

  typedef struct packed {
    cec_det_e detType;
    logic timeEn;
    logic [31:0] debounce;
    logic [31:0] cosThr;
    logic [31:0] durThr;
  } cec_cfg_s;

  typedef struct packed {
    cec_cfg_s cfg;
    logic level;
    logic [31:0] dbCnt;
    logic [31:0] evtCnt;
    logic [31:0] timeCnt;
    logic [31:0] evtSaved;
    logic [31:0] timeSaved;
    logic [31:0] cosSince;
    logic [31:0] durCur;
    logic durFired;
  } cec_chan_s;

  typedef struct packed {
    logic [31:0] evt;
    logic [31:0] time_;
    logic level;
  } cec_msg_chan_s;

  typedef struct packed {
    logic alarm;
    logic periodic;
    logic [NCH-1:0] enMask;
    cec_msg_chan_s [NCH-1:0] chan;
  } cec_msg_s;

  typedef struct packed {
    logic [MSDIV_W-1:0] msDiv;
    logic msTick;
    logic [9:0] msInSec;
    logic secTick;
    logic [NCH-1:0] enable;
    logic [31:0] sampPer;
    logic [31:0] guardPer;
    logic [31:0] txPer;
    logic [31:0] sampCnt;
    logic [31:0] txCnt;
    logic [31:0] guardCnt;
    logic [10:0] delayMs;
    cec_fsm_e fsm;
    logic [NCH-1:0] pendAlarm;
    logic pendPeriodic;
    logic msgValid;
    cec_msg_s msg;
    logic [DW-1:0] rdata;
    cec_chan_s [NCH-1:0] chan;
  } cec_state_s;

endpackage

/* verilog/cec_contact_event_counter.sv */
// What this block does
// - Alarm message waits one second after detection
// - Detection keeps running while message is sent
// - Link state never gates detection or counting
// - Sending never clears event or time counters
// - Counter-reset command zeroes event and time counters and their saved copies
// - Disabled input data zeroed in messages
// - State-change and duration alarms work independently
// - Count debounced events; save at sampling tick
// - Time counter sums abnormal seconds; saved periodically
// - Duration over threshold requests alert message
// - Message carries saved counters and present level
// - Each transmission clears pending alarms of both
// - Pulses shorter than debounce period are dropped
// - Threshold of qualifying events requests a message
// - Nonzero guard sets least spacing between messages
// - Zero transmission period disables periodic sends
// - Zero sampling period disables counter saving
// - High detection type qualifies contact closing
// - Detection type low, high or both
// - Input enable selects first, second or both
`timescale 1ns/100ps
module cec_contact_event_counter import cec_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  // System
  input wire logic clock,
  input wire logic nrst,
  // Contact inputs
  input wire logic contactInputFirst,
  input wire logic contactInputSecond,
  input wire logic linkUp,
  // Register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DW-1:0] regRdata,
  // Message transmitter
  output logic msgValid,
  input wire logic msgReady,
  output cec_msg_s msgData
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic isQualEdge(cec_det_e det, logic oldLvl, logic newLvl);
    logic rise;
    logic fall;
    rise = !oldLvl && newLvl;
    fall = oldLvl && !newLvl;
    case (det)
      DET_LOW: isQualEdge = fall;
      DET_HIGH: isQualEdge = rise;
      DET_BOTH: isQualEdge = rise || fall;
      default: isQualEdge = 1'b0;
    endcase
  endfunction

  // Abnormal state: closed contact, or open contact for low detection
  function automatic logic isAbnormal(cec_det_e det, logic lvl);
    case (det)
      DET_LOW: isAbnormal = !lvl;
      DET_HIGH: isAbnormal = lvl;
      DET_BOTH: isAbnormal = lvl;
      default: isAbnormal = 1'b0;
    endcase
  endfunction

  function automatic logic [AW-1:0] chanAddr(int idx, logic [AW-1:0] ofs);
    chanAddr = AW'(OFS_CH_BASE + AW'(idx) * OFS_CH_STRIDE + ofs);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cec_state_s s_r;
  cec_state_s s_nxt;
  logic [NCH-1:0] rawIn;
  assign rawIn = {contactInputSecond, contactInputFirst};

  always_comb begin
    logic saveTick;
    logic cntClear;
    logic accepted;
    logic [NCH-1:0] alarmSet;
    logic abn;
    logic qual;
    cec_chan_s c;
    saveTick = 1'b0;
    cntClear = 1'b0;
    accepted = 1'b0;
    alarmSet = '0;
    abn = 1'b0;
    qual = 1'b0;
    c = '0;
    s_nxt = s_r;
    s_nxt.msTick = 1'b0;
    s_nxt.secTick = 1'b0;
    s_nxt.rdata = '0;

    // ----------------------------------------------------------------
    // Time base: ms tick, then one-second tick
    // ----------------------------------------------------------------
    if (s_r.msDiv == MSDIV_W'(MS_CYCLES - 1)) begin
      s_nxt.msDiv = '0;
      s_nxt.msTick = 1'b1;
    end else begin
      s_nxt.msDiv = s_r.msDiv + MSDIV_W'(1);
    end
    if (s_r.msTick) begin
      if (s_r.msInSec == 10'(SEC_MS - 1)) begin
        s_nxt.msInSec = '0;
        s_nxt.secTick = 1'b1;
      end else begin
        s_nxt.msInSec = s_r.msInSec + 10'h001;
      end
    end

    // Sampling period, zero means never save
    if (s_r.secTick && s_r.sampPer != 32'h0) begin
      if (s_r.sampCnt + 32'h1 >= s_r.sampPer) begin
        s_nxt.sampCnt = '0;
        saveTick = 1'b1;
      end else begin
        s_nxt.sampCnt = s_r.sampCnt + 32'h1;
      end
    end

    // Periodic transmission, zero means alarms only
    if (s_r.secTick && s_r.txPer != 32'h0) begin
      if (s_r.txCnt + 32'h1 >= s_r.txPer) begin
        s_nxt.txCnt = '0;
        s_nxt.pendPeriodic = 1'b1;
      end else begin
        s_nxt.txCnt = s_r.txCnt + 32'h1;
      end
    end

    // Seconds since last message, saturating
    if (s_r.secTick && s_r.guardCnt != GUARD_SAT) begin
      s_nxt.guardCnt = s_r.guardCnt + 32'h1;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (regWr) begin
      case (regAddr)
        OFS_CTRL: begin
          s_nxt.enable = regWdata[CTRL_EN_LSB +: NCH];
          cntClear = regWdata[CTRL_CLR_BIT];
        end
        OFS_SAMPLE: s_nxt.sampPer = regWdata;
        OFS_GUARD: s_nxt.guardPer = regWdata;
        OFS_TXPER: s_nxt.txPer = regWdata;
        default: ;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (regAddr == chanAddr(i, OFS_CH_CFG)) begin
          s_nxt.chan[i].cfg.detType = cec_det_e'(regWdata[CFG_DET_LSB +: 2]);
          s_nxt.chan[i].cfg.timeEn = regWdata[CFG_TEN_BIT];
        end
        if (regAddr == chanAddr(i, OFS_CH_DEB)) s_nxt.chan[i].cfg.debounce = regWdata;
        if (regAddr == chanAddr(i, OFS_CH_COS)) s_nxt.chan[i].cfg.cosThr = regWdata;
        if (regAddr == chanAddr(i, OFS_CH_DUR)) s_nxt.chan[i].cfg.durThr = regWdata;
      end
    end

    // ----------------------------------------------------------------
    // Per-input detection; never gated by link or sender state
    // ----------------------------------------------------------------
    for (int i = 0; i < NCH; i++) begin
      c = s_nxt.chan[i];
      qual = 1'b0;
      if (s_r.msTick) begin
        if (rawIn[i] != c.level) begin
          if (c.dbCnt + 32'h1 >= c.cfg.debounce) begin
            c.level = rawIn[i];
            c.dbCnt = '0;
            qual = isQualEdge(c.cfg.detType, s_r.chan[i].level, rawIn[i]);
          end else begin
            c.dbCnt = c.dbCnt + 32'h1;
          end
        end else begin
          c.dbCnt = '0;
        end
      end
      if (s_r.enable[i] && qual) begin
        c.evtCnt = c.evtCnt + 32'h1;
        if (c.cfg.cosThr != 32'h0 && c.cosSince + 32'h1 >= c.cfg.cosThr) begin
          c.cosSince = '0;
          alarmSet[i] = 1'b1;
        end else begin
          c.cosSince = c.cosSince + 32'h1;
        end
      end
      abn = isAbnormal(c.cfg.detType, c.level);
      if (!abn) begin
        c.durCur = '0;
        c.durFired = 1'b0;
      end else if (s_r.secTick && s_r.enable[i]) begin
        if (c.cfg.timeEn) c.timeCnt = c.timeCnt + 32'h1;
        c.durCur = c.durCur + 32'h1;
        if (c.cfg.durThr != 32'h0 && c.durCur > c.cfg.durThr && !c.durFired) begin
          c.durFired = 1'b1; // Once per abnormal episode
          alarmSet[i] = 1'b1;
        end
      end
      if (saveTick && s_r.enable[i]) begin
        c.evtSaved = c.evtCnt;
        c.timeSaved = c.timeCnt;
      end
      if (cntClear) begin
        c.evtCnt = '0;
        c.timeCnt = '0;
        c.evtSaved = '0;
        c.timeSaved = '0;
        c.cosSince = '0;
        c.durCur = '0;
      end
      s_nxt.chan[i] = c;
    end

    // ----------------------------------------------------------------
    // Message sequencing
    // ----------------------------------------------------------------
    case (s_r.fsm)
      ST_IDLE: begin
        if (s_r.pendAlarm != '0) begin
          s_nxt.delayMs = '0;
          s_nxt.fsm = ST_DELAY;
        end else if (s_r.pendPeriodic) begin
          s_nxt.fsm = ST_GUARD;
        end
      end
      ST_DELAY: begin
        // Lets the second edge of a quick pair join one message
        if (s_r.delayMs >= SEND_DELAY_MS) begin
          s_nxt.fsm = ST_GUARD;
        end else if (s_r.msTick) begin
          s_nxt.delayMs = s_r.delayMs + 11'h001;
        end
      end
      ST_GUARD: begin
        // First tick after a send may be partial, so wait one tick more
        if (s_r.guardPer == 32'h0 || s_r.guardCnt > s_r.guardPer) begin
          s_nxt.msg.alarm = s_r.pendAlarm != '0;
          s_nxt.msg.periodic = s_r.pendPeriodic;
          s_nxt.msg.enMask = s_r.enable;
          for (int i = 0; i < NCH; i++) begin
            s_nxt.msg.chan[i].evt = s_r.enable[i] ? s_r.chan[i].evtSaved : 32'h0;
            s_nxt.msg.chan[i].time_ = (s_r.enable[i] && s_r.chan[i].cfg.timeEn) ?
              s_r.chan[i].timeSaved : 32'h0;
            s_nxt.msg.chan[i].level = s_r.enable[i] && s_r.chan[i].level;
          end
          s_nxt.msgValid = 1'b1;
          s_nxt.fsm = ST_SEND;
        end
      end
      ST_SEND: begin
        if (msgReady) begin
          accepted = 1'b1;
          s_nxt.msgValid = 1'b0;
          s_nxt.guardCnt = '0;
          s_nxt.fsm = ST_IDLE;
        end
      end
      default: begin
        s_nxt.msgValid = 1'b0;
        s_nxt.fsm = ST_IDLE;
      end
    endcase

    // Counters are left alone on send; new alarm beats the clear
    if (accepted) begin
      s_nxt.pendAlarm = '0;
      s_nxt.pendPeriodic = s_nxt.pendPeriodic && !s_r.pendPeriodic;
    end
    s_nxt.pendAlarm = s_nxt.pendAlarm | alarmSet;

    // ----------------------------------------------------------------
    // Register reads, answered next cycle
    // ----------------------------------------------------------------
    if (regRd) begin
      case (regAddr)
        OFS_CTRL: s_nxt.rdata[CTRL_EN_LSB +: NCH] = s_r.enable;
        OFS_SAMPLE: s_nxt.rdata = s_r.sampPer;
        OFS_GUARD: s_nxt.rdata = s_r.guardPer;
        OFS_TXPER: s_nxt.rdata = s_r.txPer;
        OFS_STATUS: begin
          s_nxt.rdata[ST_LVL_LSB] = s_r.chan[0].level;
          s_nxt.rdata[ST_LVL_LSB + 1] = s_r.chan[1].level;
          s_nxt.rdata[ST_PEND_LSB +: NCH] = s_r.pendAlarm;
          s_nxt.rdata[ST_PER_BIT] = s_r.pendPeriodic;
          s_nxt.rdata[ST_VALID_BIT] = s_r.msgValid;
          s_nxt.rdata[ST_LINK_BIT] = linkUp;
          s_nxt.rdata[ST_FSM_LSB +: 4] = s_r.fsm;
        end
        default: ;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (regAddr == chanAddr(i, OFS_CH_CFG)) begin
          s_nxt.rdata[CFG_DET_LSB +: 2] = s_r.chan[i].cfg.detType;
          s_nxt.rdata[CFG_TEN_BIT] = s_r.chan[i].cfg.timeEn;
        end
        if (regAddr == chanAddr(i, OFS_CH_DEB)) s_nxt.rdata = s_r.chan[i].cfg.debounce;
        if (regAddr == chanAddr(i, OFS_CH_COS)) s_nxt.rdata = s_r.chan[i].cfg.cosThr;
        if (regAddr == chanAddr(i, OFS_CH_DUR)) s_nxt.rdata = s_r.chan[i].cfg.durThr;
        if (regAddr == chanAddr(i, OFS_CH_EVT)) s_nxt.rdata = s_r.chan[i].evtCnt;
        if (regAddr == chanAddr(i, OFS_CH_TIME)) s_nxt.rdata = s_r.chan[i].timeCnt;
        if (regAddr == chanAddr(i, OFS_CH_EVTSV)) s_nxt.rdata = s_r.chan[i].evtSaved;
        if (regAddr == chanAddr(i, OFS_CH_TIMESV)) s_nxt.rdata = s_r.chan[i].timeSaved;
      end
    end

    // ----------------------------------------------------------------
    // Synchronous reset
    // ----------------------------------------------------------------
    if (!nrst) begin
      s_nxt = '0;
      s_nxt.enable = RST_ENABLE;
      s_nxt.sampPer = RST_SAMPLE;
      s_nxt.guardPer = RST_GUARD;
      s_nxt.txPer = RST_TXPER;
      s_nxt.guardCnt = GUARD_SAT; // First message is never held off
      s_nxt.fsm = ST_IDLE;
      for (int i = 0; i < NCH; i++) begin
        s_nxt.chan[i].cfg.detType = RST_DET;
        s_nxt.chan[i].cfg.timeEn = 1'b0;
        s_nxt.chan[i].cfg.debounce = RST_DEBOUNCE;
        s_nxt.chan[i].cfg.cosThr = RST_COS;
        s_nxt.chan[i].cfg.durThr = RST_DUR;
      end
    end
  end

  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  assign regRdata = s_r.rdata;
  assign msgValid = s_r.msgValid;
  assign msgData = s_r.msg;

endmodule // cec_contact_event_counter

/* tb/cec_properties.sv */
`timescale 1ns/100ps
module cec_properties import cec_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  // System
  input wire logic clock,
  input wire logic nrst,
  // Contact side
  input wire logic contactInputFirst,
  input wire logic contactInputSecond,
  input wire logic linkUp,
  // Register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DW-1:0] regRdata,
  // Message link
  input wire logic msgValid,
  input wire logic msgReady,
  input wire cec_msg_s msgData
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ------------------------------------------------
  // Guard tracking from snooped writes
  // ------------------------------------------------
  logic [31:0] guardSec;
  logic [31:0] sinceAcc;
  logic seenAcc;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      guardSec <= 32'h0;
      sinceAcc <= 32'h0;
      seenAcc <= 1'b0;
    end else begin
      if (regWr && regAddr == OFS_GUARD) begin
        guardSec <= regWdata;
      end
      // Cycles since the last accepted message
      if (msgValid && msgReady) begin
        sinceAcc <= 32'h0;
        seenAcc <= 1'b1;
      end else begin
        sinceAcc <= sinceAcc + 32'h1;
      end
    end
  end

  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  AST_VALID_HOLD:
    assert property (msgValid && !msgReady |=> msgValid && $stable(msgData))
    else $error("message dropped or changed before acceptance");
  AST_VALID_DROP:
    assert property (msgValid && msgReady |=> !msgValid)
    else $error("message request stayed after acceptance");
  AST_RDATA_IDLE:
    assert property (!regRd |=> regRdata == '0)
    else $error("read data not zero outside a read");
  AST_UNMAPPED:
    assert property (regRd && regAddr == 8'h14 |=> regRdata == '0)
    else $error("unmapped read not zero");
  AST_DIS_FIRST:
    assert property (msgValid && !msgData.enMask[0] |-> msgData.chan[0] == '0)
    else $error("disabled first input data in message");
  AST_DIS_SECOND:
    assert property (msgValid && !msgData.enMask[1] |-> msgData.chan[1] == '0)
    else $error("disabled second input data in message");
  AST_LINK_SEEN:
    assert property (regRd && regAddr == OFS_STATUS |=>
      regRdata[ST_LINK_BIT] == $past(linkUp) && regRdata[ST_VALID_BIT] == $past(msgValid))
    else $error("status link or valid bit wrong");
  AST_CTRL_BACK:
    assert property (regWr && regAddr == OFS_CTRL ##1 regRd && regAddr == OFS_CTRL |=>
      regRdata == {30'h0, $past(regWdata[1:0], 2)})
    else $error("enable readback wrong");
  AST_CLEAR:
    assert property (regWr && regAddr == OFS_CTRL && regWdata[CTRL_CLR_BIT]
      ##1 regRd && regAddr == 8'h30 |=> regRdata == '0)
    else $error("event counter not cleared");
  AST_GUARD:
    assert property ($rose(msgValid) && seenAcc && guardSec != 32'h0 |->
      longint'(sinceAcc) >= longint'(guardSec) * 1000 * MS_CYCLES)
    else $error("message inside guard period");
endmodule // cec_properties

bind cec_contact_event_counter cec_properties #(.MS_CYCLES(MS_CYCLES)) props (
  .clock, .nrst, .contactInputFirst, .contactInputSecond, .linkUp, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .msgValid, .msgReady, .msgData);

/* tb/cec_msg_sink.sv */
`timescale 1ns/100ps
module cec_msg_sink import cec_pkg::*; (
  // System
  input wire logic clock,
  input wire logic nrst,
  // Message link
  input wire logic msgValid,
  input wire cec_msg_s msgData,
  output logic msgReady,
  // Bench view
  input wire logic [7:0] stall,
  output cec_msg_s lastMsg,
  output logic [31:0] accepted,
  output logic [31:0] cycle,
  output logic [31:0] lastAccept
);
  logic [7:0] waitCnt;
  // ------------------------------------------------
  // Accept after a programmable stall
  // ------------------------------------------------
  always @(posedge clock) begin
    if (nrst) begin
      cycle <= cycle + 32'h1;
    end
    if (!nrst) begin
      cycle <= 32'h0;
      msgReady <= 1'b0;
      waitCnt <= 8'h00;
      accepted <= 32'h0;
      lastMsg <= '0;
      lastAccept <= 32'h0;
    end else if (msgValid && msgReady) begin
      msgReady <= 1'b0;
      waitCnt <= 8'h00;
      accepted <= accepted + 32'h1;
      lastMsg <= msgData;
      lastAccept <= cycle;
    end else if (msgValid) begin
      if (waitCnt >= stall) begin
        msgReady <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 8'h01;
      end
    end
  end
endmodule // cec_msg_sink

/* tb/tb_contact_event_counter.sv */
`timescale 1ns/100ps
module tb_contact_event_counter import cec_pkg::*;;
  localparam int MSC = 4;
  localparam int SEC = 1000 * MSC;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic contactInputFirst = 1'b0;
  logic contactInputSecond = 1'b0;
  logic linkUp = 1'b0;
  logic [AW-1:0] regAddr = '0;
  logic [DW-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DW-1:0] regRdata;
  logic msgValid;
  logic msgReady;
  cec_msg_s msgData;
  logic [7:0] stall = 8'h00;
  cec_msg_s lastMsg;
  logic [31:0] accepted;
  logic [31:0] cycle;
  logic [31:0] lastAccept;
  logic [31:0] rv;
  int failures = 0;
  int comparisons = 0;
  int ticks = 0;

  always #2.5 clock = ~clock;

  cec_contact_event_counter #(.MS_CYCLES(MSC)) dut (.clock, .nrst, .contactInputFirst,
    .contactInputSecond, .linkUp, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .msgValid, .msgReady, .msgData);
  cec_msg_sink sink (.clock, .nrst, .msgValid, .msgData, .msgReady, .stall, .lastMsg,
    .accepted, .cycle, .lastAccept);

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic hold(input int ms);
    repeat (ms * MSC) @(posedge clock);
    #1;
  endtask
  task automatic pulseA(input int ms);
    contactInputFirst <= 1'b1;
    hold(ms);
    contactInputFirst <= 1'b0;
    hold(60);
  endtask
  task automatic waitAcc(input logic [31:0] n, input int limit);
    for (int i = 0; i < limit && accepted == n; i++) @(posedge clock) #1;
    chk("accepted", n + 32'h1, accepted);
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_reset_map();
    logic [7:0] adr [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h2C,
      8'h40, 8'h14};
    logic [31:0] exp [10] = '{32'h3, 32'h1_5180, 32'h0, 32'h0, 32'h2, 32'h64, 32'h1,
      32'h0, 32'h2, 32'h0};
    foreach (adr[i]) begin
      rd(adr[i], rv);
      chk("reset map", exp[i], rv);
    end
    linkUp <= 1'b1;
    rd(OFS_STATUS, rv);
    chk("status link", 32'h1, 32'(rv[ST_LINK_BIT]));
    linkUp <= 1'b0;
  endtask

  task automatic test_count_alarm();
    logic [31:0] n;
    logic [31:0] t0;
    logic [31:0] a1;
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, rv);
    chk("enable", 32'h1, rv);
    wr(OFS_SAMPLE, 32'h0);
    wr(OFS_TXPER, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h32);
    wr(8'h28, 32'h3);
    pulseA(30);
    rd(8'h30, rv);
    chk("short pulse", 32'h0, rv);
    pulseA(60);
    pulseA(60);
    rd(8'h30, rv);
    chk("closures", 32'h2, rv);
    chk("early request", 32'h0, 32'(msgValid));
    stall <= 8'hFA;
    n = accepted;
    t0 = cycle;
    pulseA(60);
    for (int i = 0; i < 2 * SEC && msgValid !== 1'b1; i++) @(posedge clock) #1;
    chk("delay low", 32'h1, 32'(cycle - t0 >= SEC + 49 * MSC));
    chk("delay high", 32'h1, 32'(cycle - t0 <= SEC + 55 * MSC));
    // Closure while the sink stalls
    pulseA(55);
    waitAcc(n, SEC);
    chk("alarm", 32'h1, 32'(lastMsg.alarm));
    chk("mask", 32'h1, 32'(lastMsg.enMask));
    chk("off input", 32'h1, 32'(lastMsg.chan[1] === '0));
    chk("saved evt", 32'h0, lastMsg.chan[0].evt);
    chk("time", 32'h0, lastMsg.chan[0].time_);
    chk("level", 32'h0, 32'(lastMsg.chan[0].level));
    rd(8'h30, rv);
    chk("evt after send", 32'h4, rv);
    stall <= 8'h00;
    wr(OFS_GUARD, 32'h4);
    a1 = lastAccept;
    n = accepted;
    repeat (3) pulseA(60);
    waitAcc(n, 6 * SEC);
    chk("guard spacing", 32'h1, 32'(lastAccept - a1 >= 4 * SEC));
    wr(OFS_CTRL, 32'h5);
    rd(8'h30, rv);
    chk("cleared", 32'h0, rv);
  endtask

  task automatic test_duration();
    logic [31:0] n;
    wr(OFS_CTRL, 32'h2);
    wr(OFS_SAMPLE, 32'h1);
    wr(OFS_GUARD, 32'h0);
    wr(8'h40, 32'h5);
    wr(8'h44, 32'h32);
    wr(8'h48, 32'h0);
    wr(8'h4C, 32'h1);
    n = accepted;
    contactInputSecond <= 1'b1;
    waitAcc(n, 4 * SEC);
    chk("dur alarm", 32'h1, 32'(lastMsg.alarm));
    chk("mask", 32'h2, 32'(lastMsg.enMask));
    chk("off input", 32'h1, 32'(lastMsg.chan[0] === '0));
    chk("level", 32'h1, 32'(lastMsg.chan[1].level));
    chk("saved evt", 32'h1, lastMsg.chan[1].evt);
    chk("saved time", 32'h1, 32'(lastMsg.chan[1].time_ >= 1));
    hold(1000);
    chk("one per episode", n + 32'h1, accepted);
    rd(8'h54, rv);
    chk("live time", 32'h1, 32'(rv >= 3));
    rd(8'h58, rv);
    chk("saved evt", 32'h1, rv);
    contactInputSecond <= 1'b0;
  endtask

  task automatic test_periodic_low();
    logic [31:0] n;
    wr(OFS_CTRL, 32'h1);
    wr(8'h20, 32'h0);
    wr(OFS_TXPER, 32'h1);
    n = accepted;
    waitAcc(n, 2 * SEC);
    chk("periodic", 32'h1, 32'(lastMsg.periodic));
    chk("no alarm", 32'h0, 32'(lastMsg.alarm));
    // Only the opening of the contact counts for low detection
    pulseA(60);
    rd(8'h30, rv);
    chk("falling edge", 32'h1, rv);
    n = accepted;
    waitAcc(n, 2 * SEC);
    chk("periodic evt", 32'h1, lastMsg.chan[0].evt);
  endtask

  // ------------------------------------------------
  // Run control
  // ------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    ticks++;
    if (ticks == 90000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock) #1;
    test_reset_map();
    test_count_alarm();
    test_duration();
    test_periodic_low();
    report_and_stop();
  end
endmodule // tb_contact_event_counter
